// [vrsp_port.sv]
// Serial command port top: pin sync, command decode, operation tracking
`timescale 1ns/1ps
`default_nettype none
module vrsp_port (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Serial pins
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  output logic miso,
  output logic miso_oe_n,
  // Attention line, open drain
  output logic attn_n_out,
  output logic attn_n_oe_n,
  // Storage engine events
  input wire logic marker_hit,
  input wire logic row_done,
  // Operation state
  output vrsp_pkg::vrsp_op_t op_state,
  output logic powered,
  output logic wake_ready,
  output logic [vrsp_pkg::ROW_W-1:0] row_pointer,
  output logic message_end_flag,
  output logic memory_full_flag,
  output logic attention,
  output logic cmd_strobe
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] sclk_q;
  logic [1:0] mosi_q;
  logic [1:0] ss_q;
  logic sclk_d;
  logic ss_d;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sclk_q <= 2'h0;
      mosi_q <= 2'h0;
      ss_q <= 2'h3;
      sclk_d <= 1'b0;
      ss_d <= 1'b1;
    end else begin
      sclk_q <= {sclk_q[0], sclk};
      mosi_q <= {mosi_q[0], mosi};
      ss_q <= {ss_q[0], ss_n};
      sclk_d <= sclk_q[1];
      ss_d <= ss_q[1];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic frame_end;
  assign sclk_rise = sclk_q[1] && !sclk_d;
  assign sclk_fall = !sclk_q[1] && sclk_d;
  assign frame_start = ss_d && !ss_q[1];
  assign frame_end = !ss_d && ss_q[1];

  // ----------------------------------------
  // Shifter
  // ----------------------------------------
  vrsp_pkg::vrsp_frame_t frame;
  vrsp_pkg::vrsp_status_t status_word;
  logic [4:0] bit_count;

  // Row pointer on top, full flag leaves first
  assign status_word = {row_pointer, message_end_flag, memory_full_flag};

  vrsp_shifter u_shifter (
    .clk_sys(clk_sys),
    .reset(reset),
    .frame_start(frame_start),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall),
    .mosi_s(mosi_q[1]),
    .ss_n_s(ss_q[1]),
    .status_in(status_word),
    .miso(miso),
    .frame(frame),
    .bit_count(bit_count)
  );

  assign miso_oe_n = ss_q[1];
  assign attn_n_out = 1'b0;
  assign attn_n_oe_n = !attention;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_WAKE = 3'h1,
    CMD_STOP = 3'h3,
    CMD_SLEEP = 3'h2,
    CMD_START = 3'h6
  } vrsp_cmd_t;

  function automatic logic is_stop(input vrsp_pkg::vrsp_ctrl_t c);
    is_stop = !c.run && c.ignore_addr;
  endfunction

  function automatic logic is_start(input vrsp_pkg::vrsp_ctrl_t c);
    is_start = c.run && c.power;
  endfunction

  function automatic logic is_wake(input vrsp_pkg::vrsp_ctrl_t c);
    is_wake = c.power && !c.run && !c.skip && !c.ignore_addr && !c.direction;
  endfunction

  // Stop patterns first, then the exact wake pattern, then starts
  function automatic vrsp_cmd_t decode_cmd(input vrsp_pkg::vrsp_ctrl_t c);
    if (is_stop(c)) begin
      decode_cmd = c.power ? CMD_STOP : CMD_SLEEP;
    end else if (is_wake(c)) begin
      decode_cmd = CMD_WAKE;
    end else if (is_start(c)) begin
      decode_cmd = CMD_START;
    end else begin
      decode_cmd = CMD_NONE;
    end
  endfunction

  // Skip only rides on playback; with capture it starts nothing
  function automatic vrsp_pkg::vrsp_op_t start_op(input vrsp_pkg::vrsp_ctrl_t c);
    if (!c.direction) begin
      start_op = c.skip ? vrsp_pkg::OP_IDLE : vrsp_pkg::OP_CAPTURE;
    end else if (c.skip) begin
      start_op = vrsp_pkg::OP_SKIP;
    end else begin
      start_op = vrsp_pkg::OP_PLAY;
    end
  endfunction

  logic frame_ok;
  vrsp_pkg::vrsp_ctrl_t c;
  vrsp_cmd_t cmd;
  logic start_ok;
  logic row_ok;

  assign frame_ok = frame_end && bit_count == vrsp_pkg::FRAME_BITS;
  assign c = frame.ctrl;
  assign cmd = frame_ok ? decode_cmd(c) : CMD_NONE;
  assign start_ok = cmd == CMD_START && powered && op_state == vrsp_pkg::OP_IDLE;
  assign row_ok = frame.row_select_field < vrsp_pkg::ROW_COUNT;

  // ----------------------------------------
  // Engine events
  // ----------------------------------------
  logic at_end;
  logic hit_marker;
  logic hit_full;
  logic step_row;

  assign at_end = row_pointer == vrsp_pkg::ROW_LAST;

  // Capture runs past markers; only play and skip stop on them
  always_comb begin
    hit_marker = 1'b0;
    hit_full = 1'b0;
    step_row = 1'b0;
    case (op_state)
      vrsp_pkg::OP_PLAY, vrsp_pkg::OP_SKIP: begin
        if (marker_hit) begin
          hit_marker = 1'b1;
        end else if (row_done) begin
          hit_full = at_end;
          step_row = !at_end;
        end
      end
      vrsp_pkg::OP_CAPTURE: begin
        if (row_done) begin
          hit_full = at_end;
          step_row = !at_end;
        end
      end
      default: begin
        hit_marker = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Operation state
  // ----------------------------------------
  vrsp_pkg::vrsp_op_t next_op_state;
  logic [vrsp_pkg::ROW_W-1:0] next_row_pointer;
  logic next_message_end_flag;
  logic next_memory_full_flag;
  logic next_attention;
  logic next_cmd_strobe;
  logic op_ends;

  // Only an engine stop raises attention, a stop command does not
  assign op_ends = hit_marker || hit_full;

  always_comb begin
    next_op_state = op_state;
    next_row_pointer = row_pointer;
    next_message_end_flag = message_end_flag;
    next_memory_full_flag = memory_full_flag;
    next_attention = attention;
    next_cmd_strobe = frame_ok;
    if (hit_marker) begin
      next_message_end_flag = 1'b1;
      next_op_state = vrsp_pkg::OP_IDLE;
    end
    if (hit_full) begin
      next_memory_full_flag = 1'b1;
      next_op_state = vrsp_pkg::OP_IDLE;
    end
    if (step_row) begin
      next_row_pointer = row_pointer + 11'h001;
    end
    // Set wins over the clear of a frame starting in the same cycle
    if (op_ends) begin
      next_attention = 1'b1;
    end else if (frame_start) begin
      // Status already latched into the shifter this cycle
      next_attention = 1'b0;
      next_message_end_flag = 1'b0;
      next_memory_full_flag = 1'b0;
    end
    case (cmd)
      CMD_STOP, CMD_SLEEP: begin
        next_op_state = vrsp_pkg::OP_IDLE;
      end
      CMD_START: begin
        if (start_ok) begin
          if (!c.ignore_addr && row_ok) begin
            next_row_pointer = frame.row_select_field;
          end
          next_op_state = start_op(c);
        end
      end
      default: begin
        next_cmd_strobe = frame_ok;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      op_state <= vrsp_pkg::OP_IDLE;
      row_pointer <= vrsp_pkg::ROW_RESET;
      message_end_flag <= 1'b0;
      memory_full_flag <= 1'b0;
      attention <= 1'b0;
      cmd_strobe <= 1'b0;
    end else begin
      op_state <= next_op_state;
      row_pointer <= next_row_pointer;
      message_end_flag <= next_message_end_flag;
      memory_full_flag <= next_memory_full_flag;
      attention <= next_attention;
      cmd_strobe <= next_cmd_strobe;
    end
  end

  // ----------------------------------------
  // Power and wake delay
  // ----------------------------------------
  logic next_powered;
  logic [31:0] wake_count;
  logic [31:0] next_wake_count;
  logic next_wake_ready;

  // Wake ready is a hint only; commands are not held back by it
  always_comb begin
    next_powered = powered;
    next_wake_count = wake_count;
    next_wake_ready = wake_ready;
    if (wake_count != 32'h0) begin
      next_wake_count = wake_count - 32'h1;
      next_wake_ready = (wake_count == 32'h1);
    end
    case (cmd)
      CMD_SLEEP: begin
        next_powered = 1'b0;
        next_wake_ready = 1'b0;
        next_wake_count = 32'h0;
      end
      CMD_WAKE: begin
        if (!powered) begin
          next_powered = 1'b1;
          next_wake_ready = 1'b0;
          next_wake_count = 32'(vrsp_pkg::WAKE_DELAY_CYC);
        end
      end
      default: begin
        next_powered = powered;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      powered <= 1'b0;
      wake_count <= 32'h0;
      wake_ready <= 1'b0;
    end else begin
      powered <= next_powered;
      wake_count <= next_wake_count;
      wake_ready <= next_wake_ready;
    end
  end

endmodule
`default_nettype wire

// [vrsp_pkg.sv]
// Constants and types for the voice recorder serial command port
package vrsp_pkg;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int ROW_W = 11;
  localparam int CTRL_W = 5;
  localparam int FRAME_W = ROW_W + CTRL_W;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [ROW_W-1:0] ROW_COUNT = 11'h4B0;
  localparam logic [ROW_W-1:0] ROW_LAST = 11'h4AF;
  localparam int CELLS_PER_ROW = 1600;
  localparam logic [ROW_W-1:0] ROW_RESET = 11'h000;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int WAKE_DELAY_MS = 25;
  localparam int WAKE_DELAY_CYC = WAKE_DELAY_MS * CLK_MHZ * 1000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic run;
    logic direction;
    logic power;
    logic ignore_addr;
    logic skip;
  } vrsp_ctrl_t;

  typedef struct packed {
    vrsp_ctrl_t ctrl;
    logic [ROW_W-1:0] row_select_field;
  } vrsp_frame_t;

  typedef struct packed {
    logic [ROW_W-1:0] row_pointer_field;
    logic message_end_flag;
    logic memory_full_flag;
  } vrsp_status_t;

  typedef enum logic [1:0] {
    OP_IDLE = 2'h0,
    OP_PLAY = 2'h1,
    OP_SKIP = 2'h3,
    OP_CAPTURE = 2'h2
  } vrsp_op_t;

endpackage

// [vrsp_shifter.sv]
// Serial shifter for command frames and status word
`timescale 1ns/1ps
`default_nettype none
module vrsp_shifter (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Synchronised serial events
  input wire logic frame_start,
  input wire logic sclk_rise,
  input wire logic sclk_fall,
  input wire logic mosi_s,
  input wire logic ss_n_s,
  // Status to send
  input wire vrsp_pkg::vrsp_status_t status_in,
  // Outputs
  output logic miso,
  output vrsp_pkg::vrsp_frame_t frame,
  output logic [4:0] bit_count
);

  logic [vrsp_pkg::FRAME_W-1:0] rx;
  logic [vrsp_pkg::FRAME_W-1:0] tx;
  logic [vrsp_pkg::FRAME_W-1:0] next_rx;
  logic [vrsp_pkg::FRAME_W-1:0] next_tx;
  logic [4:0] next_bit_count;
  logic next_miso;
  logic [vrsp_pkg::FRAME_W-1:0] status_wide;

  // Status word zero-padded to the frame width
  assign status_wide = {{(vrsp_pkg::FRAME_W - $bits(vrsp_pkg::vrsp_status_t)){1'b0}}, status_in};

  always_comb begin
    next_rx = rx;
    next_tx = tx;
    next_bit_count = bit_count;
    next_miso = miso;
    if (frame_start) begin
      // Status loaded at frame start, bit 0 presented first
      next_tx = {1'b0, status_wide[vrsp_pkg::FRAME_W-1:1]};
      next_miso = status_wide[0];
      next_bit_count = 5'h00;
    end else if (!ss_n_s) begin
      if (sclk_rise && bit_count != vrsp_pkg::FRAME_BITS) begin
        // LSB first: each new bit enters at the top
        next_rx = {mosi_s, rx[vrsp_pkg::FRAME_W-1:1]};
        next_bit_count = bit_count + 5'h01;
      end
      if (sclk_fall) begin
        next_miso = tx[0];
        next_tx = {1'b0, tx[vrsp_pkg::FRAME_W-1:1]};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx <= '0;
      tx <= '0;
      bit_count <= 5'h00;
      miso <= 1'b0;
    end else begin
      rx <= next_rx;
      tx <= next_tx;
      bit_count <= next_bit_count;
      miso <= next_miso;
    end
  end

  assign frame = vrsp_pkg::vrsp_frame_t'(rx);

endmodule
`default_nettype wire

// [vrsp_port_assertions.sv]
// Concurrent checks on the serial command port pins and operation state
`timescale 1ns/1ps
`default_nettype none
module vrsp_port_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Pins and engine events
  input wire logic ss_n,
  input wire logic miso_oe_n,
  input wire logic attn_n_out,
  input wire logic attn_n_oe_n,
  input wire logic marker_hit,
  input wire logic row_done,
  // State
  input wire vrsp_pkg::vrsp_op_t op_state,
  input wire logic [vrsp_pkg::ROW_W-1:0] row_pointer,
  input wire logic message_end_flag,
  input wire logic memory_full_flag,
  input wire logic attention,
  input wire logic cmd_strobe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_frame_drive: assert property ($fell(ss_n) |-> ##[1:4] !miso_oe_n)
    else $error("miso not driven after select fell");
  chk_out_release: assert property (ss_n [*5] |-> miso_oe_n)
    else $error("miso driven outside a frame");
  chk_attn_pin: assert property (attention |-> !attn_n_oe_n && !attn_n_out)
    else $error("attention not on pin");
  chk_marker_stop: assert property (marker_hit && (op_state == vrsp_pkg::OP_PLAY ||
    op_state == vrsp_pkg::OP_SKIP) |=> attention && message_end_flag &&
    op_state == vrsp_pkg::OP_IDLE)
    else $error("marker did not stop with attention");
  chk_full_stop: assert property (row_done && row_pointer == vrsp_pkg::ROW_LAST &&
    op_state != vrsp_pkg::OP_IDLE |=> memory_full_flag && attention &&
    op_state == vrsp_pkg::OP_IDLE)
    else $error("last row did not overflow");
  chk_row_step: assert property (row_done && row_pointer != vrsp_pkg::ROW_LAST &&
    op_state != vrsp_pkg::OP_IDLE |=> row_pointer == $past(row_pointer) + 11'h001)
    else $error("row pointer did not advance");
  chk_attn_clear: assert property ($fell(ss_n) |-> ##[2:6] !attention)
    else $error("attention kept after frame start");
  chk_act_after: assert property (cmd_strobe |-> ss_n && $past(ss_n, 3))
    else $error("command taken inside a frame");
  chk_strobe_once: assert property (cmd_strobe |=> !cmd_strobe)
    else $error("command strobe too long");
endmodule
bind vrsp_port vrsp_port_assertions u_vrsp_port_assertions (.clk_sys(clk_sys),
  .reset(reset), .ss_n(ss_n), .miso_oe_n(miso_oe_n), .attn_n_out(attn_n_out),
  .attn_n_oe_n(attn_n_oe_n), .marker_hit(marker_hit), .row_done(row_done),
  .op_state(op_state), .row_pointer(row_pointer), .message_end_flag(message_end_flag),
  .memory_full_flag(memory_full_flag), .attention(attention), .cmd_strobe(cmd_strobe));
`default_nettype wire

// [vrsp_master.sv]
// Serial bus master model driving the command port
`timescale 1ns/1ps
`default_nettype none
module vrsp_master (
  // Clock
  input wire logic clk_sys,
  // Serial pins
  output logic sclk,
  output logic mosi,
  output logic ss_n,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
  end
  // Serial clock stands still between frames
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk_sys);
    ss_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      mosi <= w[i];
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b1;
      rx[i] = miso;
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    ss_n <= 1'b1;
    mosi <= ~mosi;
    repeat (10) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// [vrsp_port_bench.sv]
// Self-checking bench for the serial command port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module vrsp_port_bench;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic marker_hit = 1'b0;
  logic row_done = 1'b0;
  wire logic sclk, mosi, ss_n, miso, miso_oe_n, attn_n_out, attn_n_oe_n;
  vrsp_pkg::vrsp_op_t op_state;
  logic powered, wake_ready, message_end_flag, memory_full_flag, attention, cmd_strobe;
  logic [10:0] row_pointer;
  logic [10:0] cur = 11'h000;
  logic [15:0] lfsr = 16'h0005;
  logic [15:0] rx;
  logic [13:0] exp_q[$];
  logic [13:0] e;
  logic [4:0] tbl_c [14] = '{5'h04, 5'h1C, 5'h06, 5'h14, 5'h0E, 5'h1D, 5'h06, 5'h1E,
    5'h0E, 5'h16, 5'h02, 5'h1C, 5'h04, 5'h1F};
  logic [1:0] tbl_op [14] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h3, 2'h0, 2'h1, 2'h0,
    2'h2, 2'h0, 2'h0, 2'h0, 2'h3};
  logic [13:0] tbl_pw = 14'h33FF;
  int error_cnt = 0;
  int tests_run = 0;
  always #10 clk_sys = ~clk_sys;
  vrsp_port u_vrsp_port (.clk_sys(clk_sys), .reset(reset), .sclk(sclk), .mosi(mosi),
    .ss_n(ss_n), .miso(miso), .miso_oe_n(miso_oe_n), .attn_n_out(attn_n_out),
    .attn_n_oe_n(attn_n_oe_n), .marker_hit(marker_hit), .row_done(row_done),
    .op_state(op_state), .powered(powered), .wake_ready(wake_ready),
    .row_pointer(row_pointer), .message_end_flag(message_end_flag),
    .memory_full_flag(memory_full_flag), .attention(attention), .cmd_strobe(cmd_strobe));
  vrsp_master u_vrsp_master (.clk_sys(clk_sys), .sclk(sclk), .mosi(mosi), .ss_n(ss_n),
    .miso(miso));
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic cmd(input logic [4:0] c, input logic [10:0] r, input logic [1:0] op,
      input logic pw);
    if (op != 2'h0 && !c[1] && r < vrsp_pkg::ROW_COUNT) cur = r;
    exp_q.push_back({op, pw, cur});
    u_vrsp_master.xfer({c, r}, 16, rx);
  endtask
  task automatic pulse_done();
    row_done <= 1'b1;
    @(posedge clk_sys);
    row_done <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Scoreboard: state two cycles after the strobe of each accepted frame
  always @(posedge clk_sys) begin
    if (cmd_strobe === 1'b1) begin
      repeat (2) @(posedge clk_sys);
      e = exp_q.pop_front();
      `CHK("op_state", e[13:12], op_state)
      `CHK("powered", e[11], powered)
      `CHK("row_pointer", e[10:0], row_pointer)
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 14; i++) begin
      lfsr = lfsr_next(lfsr);
      cmd(tbl_c[i], {1'b0, lfsr[9:0]}, tbl_op[i], tbl_pw[i]);
    end
    `CHK("wake_ready", 1'b0, wake_ready)
    $display("test command table done");
    marker_hit <= 1'b1;
    @(posedge clk_sys);
    marker_hit <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("attention", 1'b1, attention)
    cmd(5'h06, 11'h000, 2'h0, 1'b1);
    `CHK("status", {3'h0, cur, 1'b1, 1'b0}, rx)
    `CHK("attention", 1'b0, attention)
    $display("test marker done");
    cmd(5'h14, 11'h4AF, 2'h2, 1'b1);
    pulse_done();
    `CHK("memory_full_flag", 1'b1, memory_full_flag)
    cmd(5'h06, 11'h000, 2'h0, 1'b1);
    `CHK("status", {3'h0, 11'h4AF, 1'b0, 1'b1}, rx)
    $display("test overflow done");
    lfsr = lfsr_next(lfsr);
    cmd(5'h14, {1'b0, lfsr[9:0]}, 2'h2, 1'b1);
    pulse_done();
    pulse_done();
    cur = cur + 11'h002;
    cmd(5'h0E, 11'h000, 2'h0, 1'b1);
    u_vrsp_master.xfer({5'h1C, 11'h00A}, 15, rx);
    cmd(5'h06, 11'h000, 2'h0, 1'b1);
    $display("test row step and short frame done");
    cmd(5'h1C, 11'h4B0, 2'h1, 1'b1);
    cmd(5'h0E, 11'h000, 2'h0, 1'b1);
    $display("test row refusal done");
    print_verdict();
  end
  initial begin
    #500_000;
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
